// *** design/htlog_top.v ***
/*
  Health log temperature tail and firmware slot information log, with an
  AXI4-Lite register slave, page readout by byte offset and one interrupt.
  Assumes a synchronous AXI4-Lite master on the same clock; sensor readings
  arrive as kelvin values already synchronous to the clock.
*/
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "htlog_defines.vh"

// Contract
// - Count minutes operational with composite temperature above critical threshold, bytes 199:196.
// - Critical threshold zero keeps that minute counter at zero.
// - Eight two-byte sensor fields, sensor one at 201:200 to eight at 215:214.
// - Each sensor field holds kelvin temperature unsigned in bits 15:0.
// - Unimplemented sensor positions report zero.
// - Sensor temperature may raise an event toward the host.
// - One controller-wide firmware slot page under log identifier 03h.
// - First byte bits 2:0 give slot of running firmware.
// - First byte bits 6:4 give next-reset slot; zero means not indicated.
// - Eight-byte ASCII revision per slot one to seven, bytes 15:08 to 63:56.
// - Invalid or unsupported slot returns all-zero revision bytes.
module htlog_top #(
  parameter [31:0] MINUTE_CYCLES = `HTLOG_MINUTE_CYCLES,
  parameter [7:0] SENSOR_PRESENT = 8'hFF,
  parameter [6:0] SLOT_SUPPORTED = 7'h7F
) (
  input wire clock,
  input wire rst,
  input wire [15:0] composite_temp,
  input wire [127:0] sensor_kelvin_reading,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq
);

  reg [1:0] ctrl_reg;
  reg [15:0] thresh_reg;
  reg [2:0] act_slot_reg;
  reg [2:0] next_slot_reg;
  reg [6:0] rev_valid_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  reg [7:0] log_sel_reg;
  reg [4:0] log_page_hi_reg;
  reg [31:0] rev_reg [0:13];
  reg [7:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_have_reg;
  reg [7:0] sens_over_reg;
  reg crit_level_reg;

  wire [31:0] crit_minutes;
  wire minute_tick;
  wire do_write;
  wire [2:0] ev_set;
  wire [7:0] sens_over;
  wire crit_now;
  integer i;

  htlog_minute_counter #(
    .MINUTE_CYCLES(MINUTE_CYCLES)
  ) u_minutes (
    .clock(clock),
    .rst(rst),
    .operational(ctrl_reg[`HTLOG_CTRL_OPER_BIT]),
    .composite_temp(composite_temp),
    .critical_temp_threshold(thresh_reg),
    .minutes_reg(crit_minutes),
    .minute_tick_reg(minute_tick)
  );

  // Sensor field, absent positions forced to zero
  function [15:0] sensor_field;
    input [2:0] idx;
    begin
      sensor_field = SENSOR_PRESENT[idx] ? sensor_kelvin_reading[idx*16 +: 16] : 16'h0000;
    end
  endfunction

  // Revision word of slot s (1..7), half h; invalid or unsupported gives zero
  function [31:0] rev_word;
    input [2:0] slot;
    input half;
    begin
      if (slot == 3'h0 || !SLOT_SUPPORTED[slot - 3'h1] || !rev_valid_reg[slot - 3'h1])
        rev_word = 32'h00000000;
      else
        rev_word = rev_reg[{slot - 3'h1, half}];
    end
  endfunction

  // Active slot byte with reserved bits 7 and 3 at zero
  function [7:0] active_slot_info;
    input dummy;
    begin
      active_slot_info = {1'b0, next_slot_reg, 1'b0, act_slot_reg};
    end
  endfunction

  // Page word readout at byte offset byte_off, log chosen by identifier
  function [31:0] log_word;
    input [7:0] lid;
    input [9:0] byte_off;
    reg [7:0] widx;
    reg [1:0] sidx;
    begin
      widx = byte_off[9:2];
      // Word 50 holds sensors one and two, so the pair index is offset by two
      sidx = widx[1:0] + 2'b10;
      log_word = 32'h00000000;
      if (lid == `HTLOG_LID_HEALTH) begin
        if (widx == `HTLOG_HP_CRIT_BYTE / 4)
          log_word = crit_minutes;
        else if (widx >= `HTLOG_HP_SENS_BYTE / 4 && widx < `HTLOG_HP_END_BYTE / 4)
          log_word = {sensor_field({sidx, 1'b1}), sensor_field({sidx, 1'b0})};
      end else if (lid == `HTLOG_LID_FWSLOT) begin
        if (widx == 8'h00)
          log_word = {24'h000000, active_slot_info(1'b0)};
        else if (widx >= `HTLOG_FP_REV_BYTE / 4 && widx < `HTLOG_FP_END_BYTE / 4)
          log_word = rev_word(widx[3:1], widx[0]);
      end
      // Everything else, including bytes 511:216 and 511:64, reads zero
    end
  endfunction

  assign crit_now = ctrl_reg[`HTLOG_CTRL_OPER_BIT] && thresh_reg != 16'h0000 && composite_temp > thresh_reg;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sens
      assign sens_over[g] = thresh_reg != 16'h0000 && SENSOR_PRESENT[g] && sensor_kelvin_reading[g*16 +: 16] > thresh_reg;
    end
  endgenerate

  // Critical and sensor events on rising edges only, so a steady hot condition does not refire them after clear
  assign ev_set[`HTLOG_ST_CRIT_BIT] = ctrl_reg[`HTLOG_CTRL_EV_EN_BIT] && crit_now && !crit_level_reg;
  assign ev_set[`HTLOG_ST_SENS_BIT] = ctrl_reg[`HTLOG_CTRL_EV_EN_BIT] && |(sens_over & ~sens_over_reg);
  assign ev_set[`HTLOG_ST_MIN_BIT] = minute_tick;

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= 2'b01;
      thresh_reg <= 16'h0000;
      act_slot_reg <= 3'h1;
      next_slot_reg <= 3'h0;
      rev_valid_reg <= 7'h00;
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
      log_sel_reg <= `HTLOG_LID_HEALTH;
      crit_level_reg <= 1'b0;
      sens_over_reg <= 8'h00;
      irq <= 1'b0;
      for (i = 0; i < 14; i = i + 1)
        rev_reg[i] <= 32'h00000000;
    end else begin
      crit_level_reg <= crit_now;
      sens_over_reg <= sens_over;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Set wins over a write-one clear in the same cycle
      status_reg <= status_reg | ev_set;
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr_reg)
          `HTLOG_REG_CTRL: if (w_strb_reg[0]) ctrl_reg <= w_data_reg[1:0];
          `HTLOG_REG_THRESH: begin
            if (w_strb_reg[0]) thresh_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) thresh_reg[15:8] <= w_data_reg[15:8];
          end
          `HTLOG_REG_SLOTS: if (w_strb_reg[0]) begin
            act_slot_reg <= w_data_reg[`HTLOG_SLOT_ACT_LSB +: 3];
            next_slot_reg <= w_data_reg[`HTLOG_SLOT_NEXT_LSB +: 3];
          end
          `HTLOG_REG_VALID: if (w_strb_reg[0]) rev_valid_reg <= w_data_reg[6:0];
          `HTLOG_REG_STATUS: if (w_strb_reg[0]) status_reg <= (status_reg & ~w_data_reg[2:0]) | ev_set;
          `HTLOG_REG_MASK: if (w_strb_reg[0]) mask_reg <= w_data_reg[2:0];
          `HTLOG_REG_LOG_SEL: if (w_strb_reg[0]) log_sel_reg <= w_data_reg[7:0];
          default: begin
            if (aw_addr_reg >= `HTLOG_REG_REV_BASE && aw_addr_reg < `HTLOG_REG_REV_BASE + 8'h38) begin
              for (i = 0; i < 4; i = i + 1)
                if (w_strb_reg[i])
                  rev_reg[aw_addr_reg[5:2]][i*8 +: 8] <= w_data_reg[i*8 +: 8];
            end else begin
              s_axi_bresp <= 2'b10;
            end
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      irq <= |((status_reg | ev_set) & mask_reg);
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  always @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `HTLOG_REG_CTRL: s_axi_rdata <= {30'h00000000, ctrl_reg};
          `HTLOG_REG_THRESH: s_axi_rdata <= {16'h0000, thresh_reg};
          `HTLOG_REG_SLOTS: s_axi_rdata <= {24'h000000, active_slot_info(1'b0)};
          `HTLOG_REG_VALID: s_axi_rdata <= {25'h0000000, rev_valid_reg};
          `HTLOG_REG_STATUS: s_axi_rdata <= {29'h00000000, status_reg};
          `HTLOG_REG_MASK: s_axi_rdata <= {29'h00000000, mask_reg};
          `HTLOG_REG_CRIT_MIN: s_axi_rdata <= crit_minutes;
          `HTLOG_REG_LOG_SEL: s_axi_rdata <= {24'h000000, log_sel_reg};
          default: begin
            // Page window: byte offset is LOG_SEL bits 12:8 above address bits 4:0
            if (s_axi_araddr >= `HTLOG_REG_LOG_DATA && s_axi_araddr < `HTLOG_REG_SENS_BASE)
              s_axi_rdata <= log_word(log_sel_reg, {log_page_hi_reg, s_axi_araddr[4:0]});
            else if (s_axi_araddr >= `HTLOG_REG_SENS_BASE && s_axi_araddr < `HTLOG_REG_SENS_BASE + 8'h20)
              s_axi_rdata <= {16'h0000, sensor_field(s_axi_araddr[4:2])};
            else if (s_axi_araddr >= `HTLOG_REG_REV_BASE && s_axi_araddr < `HTLOG_REG_REV_BASE + 8'h38)
              s_axi_rdata <= rev_reg[s_axi_araddr[5:2]];
            else begin
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= 2'b10;
            end
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Page window upper offset bits, taken from LOG_SEL bits 12:8
  always @(posedge clock) begin
    if (rst)
      log_page_hi_reg <= 5'h00;
    else if (do_write && aw_addr_reg == `HTLOG_REG_LOG_SEL && w_strb_reg[1])
      log_page_hi_reg <= w_data_reg[12:8];
  end

endmodule

`default_nettype wire

// *** common/htlog_defines.vh ***
/*
  Shared constants for the health-temperature and firmware-slot log block:
  register offsets, field positions, page byte offsets and timing counts.
  Assumes a 40 MHz controller clock and 32-bit AXI4-Lite register access.
*/
`ifndef HTLOG_DEFINES_VH
`define HTLOG_DEFINES_VH

// Register byte offsets
`define HTLOG_REG_CTRL       8'h00
`define HTLOG_REG_THRESH     8'h04
`define HTLOG_REG_SLOTS      8'h08
`define HTLOG_REG_VALID      8'h0C
`define HTLOG_REG_STATUS     8'h10
`define HTLOG_REG_MASK       8'h14
`define HTLOG_REG_CRIT_MIN   8'h18
`define HTLOG_REG_LOG_SEL    8'h1C
`define HTLOG_REG_LOG_DATA   8'h20
`define HTLOG_REG_SENS_BASE  8'h40
`define HTLOG_REG_REV_BASE   8'h80

// Control register fields
`define HTLOG_CTRL_OPER_BIT  0
`define HTLOG_CTRL_EV_EN_BIT 1

// Slot register fields
`define HTLOG_SLOT_ACT_LSB   0
`define HTLOG_SLOT_NEXT_LSB  4

// Status bits
`define HTLOG_ST_CRIT_BIT    0
`define HTLOG_ST_SENS_BIT    1
`define HTLOG_ST_MIN_BIT     2

// Log identifiers and page byte offsets
`define HTLOG_LID_HEALTH     8'h02
`define HTLOG_LID_FWSLOT     8'h03
`define HTLOG_HP_CRIT_BYTE   196
`define HTLOG_HP_SENS_BYTE   200
`define HTLOG_HP_END_BYTE    216
`define HTLOG_FP_REV_BYTE    8
`define HTLOG_FP_END_BYTE    64

// Timing
`define HTLOG_CLK_HZ         32'h02625A00
`define HTLOG_MINUTE_S       32'h0000003C
`define HTLOG_MINUTE_CYCLES  (`HTLOG_CLK_HZ * `HTLOG_MINUTE_S)

`endif

// *** design/htlog_minute_counter.v ***
/*
  Critical-temperature minute counter.
  Assumes a free-running controller clock and a threshold value in kelvin.
*/
`timescale 1ns/1ps
`default_nettype none

module htlog_minute_counter #(
  parameter [31:0] MINUTE_CYCLES = 32'h8F0D1800
) (
  input wire clock,
  input wire rst,
  input wire operational,
  input wire [15:0] composite_temp,
  input wire [15:0] critical_temp_threshold,
  output reg [31:0] minutes_reg,
  output reg minute_tick_reg
);

  reg [31:0] cycle_reg;
  wire hot;

  assign hot = operational && (composite_temp > critical_temp_threshold);

  always @(posedge clock) begin
    minute_tick_reg <= 1'b0;
    if (rst || critical_temp_threshold == 16'h0000) begin
      // Zero threshold forces the count and the partial minute to zero
      cycle_reg <= 32'h00000000;
      minutes_reg <= 32'h00000000;
    end else if (hot) begin
      if (cycle_reg == MINUTE_CYCLES - 32'h00000001) begin
        cycle_reg <= 32'h00000000;
        minutes_reg <= minutes_reg + 32'h00000001;
        minute_tick_reg <= 1'b1;
      end else begin
        cycle_reg <= cycle_reg + 32'h00000001;
      end
    end
  end

endmodule

`default_nettype wire

// *** verif/htlog_sva.sv ***
/* Port checker for htlog_top: AXI4-Lite answer timing and interrupt.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module htlog_sva (
  input wire clock,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_done; s_axi_rvalid && s_axi_rready; endsequence
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_release: assert property (s_rd_done |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read channel not released");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_irq_quiet: assert property ($fell(rst) |-> !irq)
    else $error("interrupt high after reset");
endmodule
bind htlog_top htlog_sva u_sva (.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

// *** verif/htlog_host_model.sv ***
/* Host side: AXI4-Lite master issuing register and log page reads.
   Assumes the slave clock; waits are bounded and counted in timeouts. */
`timescale 1ns/1ps
`default_nettype none
module htlog_host_model (
  input wire logic clock,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  integer timeouts = 0;
  logic [1:0] last_bresp = 2'b11;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  task axi_write(input [7:0] a, input [31:0] d);
    integer n;
    begin : wr
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n = n + 1) begin
        @(posedge clock);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          last_bresp = s_axi_bresp;
          s_axi_bready <= 1'b0;
          disable wr;
        end
      end
      timeouts = timeouts + 1;
    end
  endtask
  task axi_read(input [7:0] a, output [31:0] d, output [1:0] r);
    integer n;
    begin : rd
      d = 32'hDEADBEEF;
      r = 2'b11;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n = n + 1) begin
        @(posedge clock);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 1'b0;
          disable rd;
        end
      end
      timeouts = timeouts + 1;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/htlog_top_bench.sv ***
/* Self-checking bench for htlog_top through the host model.
   Assumes a short minute of 20 cycles, sensor eight absent, slot three unsupported. */
`timescale 1ns/1ps
`default_nettype none
module htlog_top_bench;
  logic clock, rst;
  logic [15:0] composite_temp;
  logic [127:0] sensor_kelvin_reading;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  integer failures = 0, comparisons = 0, k;
  logic [31:0] d;
  logic [1:0] r;
  htlog_top #(.MINUTE_CYCLES(20), .SENSOR_PRESENT(8'h7F), .SLOT_SUPPORTED(7'h7B)) DUT (.clock, .rst,
    .composite_temp, .sensor_kelvin_reading, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  htlog_host_model HOST (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  task check(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
    // A bus wait that ran out ends the run at the next comparison
    if (HOST.timeouts != 0) print_verdict;
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    HOST.axi_read(a, d, r);
    check(d, exp);
    check({30'h0, r}, 32'h0);
  endtask
  // Interrupt is looked at just after the edge, once the design's flops have settled
  task irq_chk(input logic want);
    #1;
    check({31'h0, irq}, {31'h0, want});
  endtask
  task print_verdict;
    failures = failures + HOST.timeouts;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst = 1;
    composite_temp = 16'h0;
    sensor_kelvin_reading = '0;
    repeat (2) @(posedge clock);
    rst <= 0;
    HOST.axi_write(8'h1C, 32'h3);
    rd_chk(8'h20, 32'h1);
    HOST.axi_write(8'h08, 32'hFF);
    rd_chk(8'h20, 32'h77);
    rd_chk(8'h24, 32'h0);
    $display("test slot info done");
    HOST.axi_write(8'h80, 32'h45525746);
    HOST.axi_write(8'h84, 32'h31303056);
    HOST.axi_write(8'h90, 32'h45525746);
    HOST.axi_write(8'hB0, 32'h45525746);
    HOST.axi_write(8'hB4, 32'h37303056);
    HOST.axi_write(8'h0C, 32'h05);
    rd_chk(8'h28, 32'h45525746);
    rd_chk(8'h2C, 32'h31303056);
    rd_chk(8'h38, 32'h0);
    rd_chk(8'h3C, 32'h0);
    HOST.axi_write(8'h0C, 32'h40);
    rd_chk(8'h2C, 32'h0);
    HOST.axi_write(8'h1C, 32'h103);
    rd_chk(8'h38, 32'h45525746);
    rd_chk(8'h3C, 32'h37303056);
    HOST.axi_write(8'h1C, 32'h203);
    rd_chk(8'h20, 32'h0);
    $display("test revisions done");
    for (k = 0; k < 8; k = k + 1) sensor_kelvin_reading[k*16 +: 16] <= 16'h0120 + k[15:0];
    HOST.axi_write(8'h1C, 32'h602);
    for (k = 0; k < 3; k = k + 1) rd_chk(8'h28 + 8'(4 * k), {16'h0121 + 16'(2 * k), 16'h0120 + 16'(2 * k)});
    rd_chk(8'h34, 32'h00000126);
    rd_chk(8'h38, 32'h0);
    rd_chk(8'h40, 32'h0120);
    $display("test sensors done");
    composite_temp <= 16'd350;
    HOST.axi_write(8'h14, 32'h4);
    HOST.axi_write(8'h04, 32'd300);
    repeat (70) @(posedge clock);
    rd_chk(8'h24, 32'd3);
    irq_chk(1'b1);
    HOST.axi_write(8'h04, 32'd0);
    repeat (25) @(posedge clock);
    rd_chk(8'h24, 32'h0);
    HOST.axi_write(8'h04, 32'd350);
    HOST.axi_write(8'h10, 32'h7);
    repeat (30) @(posedge clock);
    rd_chk(8'h18, 32'h0);
    irq_chk(1'b0);
    $display("test minute counter done");
    HOST.axi_write(8'h00, 32'h3);
    HOST.axi_write(8'h14, 32'h3);
    composite_temp <= 16'd351;
    rd_chk(8'h10, 32'h1);
    sensor_kelvin_reading[15:0] <= 16'd400;
    rd_chk(8'h10, 32'h3);
    irq_chk(1'b1);
    HOST.axi_write(8'h10, 32'h3);
    rd_chk(8'h10, 32'h0);
    irq_chk(1'b0);
    $display("test events done");
    HOST.axi_read(8'hFC, d, r);
    check({30'h0, r}, 32'h2);
    HOST.axi_write(8'hFC, 32'h0);
    check({30'h0, HOST.last_bresp}, 32'h2);
    HOST.axi_write(8'h1C, 32'h4);
    check({30'h0, HOST.last_bresp}, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("test unmapped done");
    print_verdict;
  end
endmodule
`default_nettype wire
